// ---- src/adcsq_pkg.sv ----
// package: register map, fields, reset values and timing for the converter sequencer
package adcsq_pkg;
    // ==========================================================
    // register map (byte addresses on the bus)
    localparam logic [3:0] ADCSQ_CTRL_OFFS   = 4'h0; // converter_channel_control
    localparam logic [3:0] ADCSQ_CFG_OFFS    = 4'h4; // clock source, irq enable, divisor
    localparam logic [3:0] ADCSQ_RESULT_OFFS = 4'h8; // result high/low bytes
    localparam logic [3:0] ADCSQ_STAT_OFFS   = 4'hC; // done flag, start pending, busy, sleep power-down
    // ==========================================================
    // control register fields
    localparam int ADCSQ_EN_BIT    = 0;
    localparam int ADCSQ_GO_BIT    = 1;
    localparam int ADCSQ_CHS_LSB   = 2;
    localparam int ADCSQ_CHS_W     = 5;
    localparam logic [7:0] ADCSQ_CTRL_RST = 8'h00;
    localparam logic [7:0] ADCSQ_CTRL_MASK = 8'h7F; // bit 7 unimplemented
    // config register fields
    localparam int ADCSQ_CFG_RC_BIT    = 0; // 1: dedicated rc clock
    localparam int ADCSQ_CFG_IRQEN_BIT = 1; // conversion_irq_enable
    localparam int ADCSQ_CFG_DIV_LSB   = 4; // system clock divisor select
    localparam logic [7:0] ADCSQ_CFG_RST = 8'h00;
    // ==========================================================
    // channel codes
    localparam logic [4:0] ADCSQ_CH_LAST_EXT = 5'h0B;
    localparam logic [4:0] ADCSQ_CH_TEMP     = 5'h1D;
    localparam logic [4:0] ADCSQ_CH_DAC      = 5'h1E;
    localparam logic [4:0] ADCSQ_CH_FVR      = 5'h1F;
    // ==========================================================
    // timing: a conversion is 23 half periods of the bit clock (11.5 periods)
    localparam int ADCSQ_RES_BITS        = 10;
    localparam logic [4:0] ADCSQ_HALF_TICKS = 5'h17;
    localparam logic [1:0] ADCSQ_AXI_OKAY   = 2'h0;
    localparam logic [1:0] ADCSQ_AXI_SLVERR = 2'h2;
endpackage

// ---- src/adcsq_sar.sv ----
// successive-approximation sequencer stepping on half-period ticks of the bit clock
`timescale 1ns/1ps
module adcsq_sar #(
    parameter int RES_BITS = 10
) (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                start_i,
    input  wire logic                abort_i,
    input  wire logic                tick_i,
    input  wire logic                cmp_i,
    output logic                     busy_o,
    output logic                     done_o,
    output logic [RES_BITS-1:0]      result_o
);
    // ==========================================================
    // checks
    // 23 half-period ticks leave room for ten decisions at most
    if (RES_BITS < 2 || RES_BITS > 10)
    begin : g_bad_res
        $error("adcsq_sar: RES_BITS out of range");
    end

    logic [4:0]          tick_cnt_reg;
    logic [RES_BITS-1:0] sar_reg;
    logic [4:0]          bits_done_reg;
    logic                last_bit_reg;

    // ==========================================================
    // tick counter, busy flag and one bit decided every second tick
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            tick_cnt_reg  <= 5'h00;
            sar_reg       <= '0;
            bits_done_reg <= 5'h00;
            last_bit_reg  <= 1'b0;
            result_o      <= '0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_o)
            begin
                busy_o        <= 1'b1;
                tick_cnt_reg  <= 5'h00;
                bits_done_reg <= 5'h00;
                sar_reg       <= '0;
            end
            else if (busy_o && abort_i)
            begin
                // partial result: undecided bits copy the last decided one [RULE19]
                busy_o <= 1'b0;
                for (int i = 0; i < RES_BITS; i++)
                    result_o[i] <= (RES_BITS - 1 - i < int'(bits_done_reg))
                                   ? sar_reg[i] : last_bit_reg;
            end
            else if (busy_o && tick_i)
            begin
                tick_cnt_reg <= tick_cnt_reg + 5'h01;
                // bit n decided on odd ticks after the first full period
                if (tick_cnt_reg[0] && tick_cnt_reg > 5'h01
                    && int'(bits_done_reg) < RES_BITS)
                begin
                    sar_reg[RES_BITS-1-int'(bits_done_reg)] <= cmp_i;
                    last_bit_reg  <= cmp_i;
                    bits_done_reg <= bits_done_reg + 5'h01;
                end
                if (tick_cnt_reg == adcsq_pkg::ADCSQ_HALF_TICKS - 5'h01)
                begin
                    busy_o   <= 1'b0; // 11.5 bit periods elapsed [RULE20]
                    done_o   <= 1'b1;
                    result_o <= sar_reg;
                end
            end
        end
    end
endmodule

// ---- src/adcsq_top.sv ----
// converter sequencing control with an axi4-lite register slave
// Function
// [RULE1] conversion continues in sleep only with the dedicated rc clock selected
// [RULE2] with rc clock, conversion start is delayed one extra instruction cycle
// [RULE3] sleep conversion with irq enabled wakes the processor at completion
// [RULE4] sleep conversion with irq disabled powers down after, enable stays set
// [RULE5] sleep with system-derived clock aborts conversion, powers down, enable set
// [RULE6] compare trigger sets go flag and clears the trigger timer
// [RULE7] software ensures trigger conversions meet timing; hardware does not
// [RULE8] channel codes 0 to 11 route external analog input n
// [RULE9] codes from 12 up to internal ones are reserved, no channel connected
// [RULE10] codes 29, 30, 31 select temperature, dac output, fixed reference
// [RULE11] writing go starts conversion; reads one while busy; cleared at end
// [RULE12] enable bit one powers converter; zero disables, no current
// [RULE13] control bit 7 unimplemented, reads zero, writes ignored
// [RULE14] software configures clock, reference, channel, then enables
// [RULE15] software waits acquisition time before setting go
// [RULE16] software polls go flag or waits for interrupt
// [RULE17] software clears the done irq flag; hardware never does
// [RULE18] completion clears go, sets irq flag, loads result bytes
// [RULE19] clearing go mid-conversion stores partial result, rest copy last bit
// [RULE20] full conversion takes 11.5 bit clock periods
// [RULE21] software sets go in a later write than the one enabling
// [RULE22] sleep conversion is sequenced wholly from the rc clock
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module adcsq_top #(
    parameter int RC_HALF_DIV = 8,   // system cycles per rc half period
    parameter int INSN_CYCLES = 4    // system cycles per instruction cycle
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device side
    input  wire logic        sleep_i,
    input  wire logic        compare_trigger_unit_i,
    input  wire logic        comparator_i,
    output logic             trigger_timer_count_clr_o,
    output logic             converter_powered_o,
    output logic             wake_o,
    output logic             conversion_done_irq_flag_o,
    output logic [11:0]      analog_input_sel_o,
    output logic             temp_indicator_sel_o,
    output logic             dac_output_sel_o,
    output logic             fixed_reference_buffer_sel_o
);
    // ==========================================================
    // checks
    if (RC_HALF_DIV < 1 || RC_HALF_DIV > 65535 || INSN_CYCLES < 1 || INSN_CYCLES > 255)
    begin : g_bad_param
        $error("adcsq_top: divider parameters out of range");
    end

    // ==========================================================
    // registers
    logic [7:0]  converter_channel_control_reg;
    logic [7:0]  cfg_reg;
    logic [9:0]  result_reg;
    logic        irq_flag_reg;
    logic        asleep_off_reg;  // converter powered down by sleep
    logic        delay_pend_reg;
    logic [7:0]  delay_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic        tick_reg;
    logic        start_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [3:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    logic        busy;
    logic        done;
    logic [9:0]  sar_result;
    logic        rc_clk_sel;
    logic        wr_fire;
    logic        wr_ctrl;
    logic        sw_go;
    logic        sw_abort;
    logic        sleep_abort;
    logic [4:0]  chs;

    assign rc_clk_sel = cfg_reg[adcsq_pkg::ADCSQ_CFG_RC_BIT];
    assign chs = converter_channel_control_reg[adcsq_pkg::ADCSQ_CHS_LSB +: adcsq_pkg::ADCSQ_CHS_W];

    // ==========================================================
    // axi4-lite write: address and data taken in either order
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && aw_addr_reg == adcsq_pkg::ADCSQ_CTRL_OFFS && w_strb_reg[0];
    assign sw_go   = wr_ctrl && w_data_reg[adcsq_pkg::ADCSQ_GO_BIT]
                     && converter_channel_control_reg[adcsq_pkg::ADCSQ_EN_BIT];
    assign sw_abort = wr_ctrl && !w_data_reg[adcsq_pkg::ADCSQ_GO_BIT] && (busy || delay_pend_reg);
    // sleep only kills a conversion clocked from the system clock [RULE5]
    assign sleep_abort = sleep_i && !rc_clk_sel && (busy || delay_pend_reg);

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= adcsq_pkg::ADCSQ_AXI_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // every aligned word is mapped; status bit 0 is write-one-clear
                s_axi_bresp  <= (aw_addr_reg[1:0] == 2'h0)
                                ? adcsq_pkg::ADCSQ_AXI_OKAY : adcsq_pkg::ADCSQ_AXI_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // control register: software fields plus hardware go/done
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            converter_channel_control_reg <= adcsq_pkg::ADCSQ_CTRL_RST;
        else
        begin
            if (wr_ctrl)
                // bit 7 never stored [RULE13]; go only set once enabled [RULE21]
                converter_channel_control_reg <= (w_data_reg[7:0] & adcsq_pkg::ADCSQ_CTRL_MASK
                    & ~(8'h01 << adcsq_pkg::ADCSQ_GO_BIT))
                    | ({7'h00, sw_go} << adcsq_pkg::ADCSQ_GO_BIT);
            // hardware sets go from the compare trigger, set wins [RULE6]
            if (compare_trigger_unit_i && converter_channel_control_reg[adcsq_pkg::ADCSQ_EN_BIT])
                converter_channel_control_reg[adcsq_pkg::ADCSQ_GO_BIT] <= 1'b1;
            else if (done || sleep_abort)
                converter_channel_control_reg[adcsq_pkg::ADCSQ_GO_BIT] <= 1'b0; // [RULE11] [RULE18]
        end
    end

    // config register (clock source, irq enable)
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cfg_reg <= adcsq_pkg::ADCSQ_CFG_RST;
        else if (wr_fire && aw_addr_reg == adcsq_pkg::ADCSQ_CFG_OFFS && w_strb_reg[0])
            cfg_reg <= w_data_reg[7:0];
    end

    // ==========================================================
    // start path: rc clock waits one extra instruction cycle
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            delay_pend_reg <= 1'b0;
            delay_cnt_reg  <= 8'h00;
            start_reg      <= 1'b0;
        end
        else
        begin
            start_reg <= 1'b0;
            if (sleep_abort || sw_abort)
                delay_pend_reg <= 1'b0;
            else if ((sw_go || (compare_trigger_unit_i
                      && converter_channel_control_reg[adcsq_pkg::ADCSQ_EN_BIT]))
                     && !busy && !delay_pend_reg)
            begin
                delay_pend_reg <= 1'b1;
                // rc source adds one instruction so sleep can run first [RULE2]
                delay_cnt_reg  <= rc_clk_sel ? 8'(INSN_CYCLES) : 8'h00;
            end
            else if (delay_pend_reg)
            begin
                if (delay_cnt_reg == 8'h00)
                begin
                    delay_pend_reg <= 1'b0;
                    start_reg      <= 1'b1;
                end
                else
                    delay_cnt_reg <= delay_cnt_reg - 8'h01;
            end
        end
    end

    // ==========================================================
    // bit clock ticks; rc ticks keep running in sleep [RULE1] [RULE22]
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            div_cnt_reg <= 16'h0000;
            tick_reg    <= 1'b0;
        end
        else
        begin
            tick_reg <= 1'b0;
            if (!rc_clk_sel && sleep_i)
                div_cnt_reg <= 16'h0000; // system clock halted in sleep
            else if (div_cnt_reg >= (rc_clk_sel ? 16'(RC_HALF_DIV - 1)
                                     : 16'(cfg_reg[7:adcsq_pkg::ADCSQ_CFG_DIV_LSB])))
            begin
                div_cnt_reg <= 16'h0000;
                tick_reg    <= 1'b1;
            end
            else
                div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    adcsq_sar #(
        .RES_BITS (adcsq_pkg::ADCSQ_RES_BITS)
    ) u_sar (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (start_reg),
        .abort_i   (sw_abort || sleep_abort),
        .tick_i    (tick_reg),
        .cmp_i     (comparator_i),
        .busy_o    (busy),
        .done_o    (done),
        .result_o  (sar_result)
    );

    // ==========================================================
    // result, irq flag, power and wake
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            result_reg                 <= 10'h000;
            irq_flag_reg               <= 1'b0;
            asleep_off_reg             <= 1'b0;
            wake_o                     <= 1'b0;
            converter_powered_o        <= 1'b0;
            conversion_done_irq_flag_o <= 1'b0;
            trigger_timer_count_clr_o  <= 1'b0;
        end
        else
        begin
            result_reg <= sar_result; // [RULE18] [RULE19]
            // completion sets flag; only a status write of one clears it [RULE17]
            if (done)
                irq_flag_reg <= 1'b1;
            else if (wr_fire && aw_addr_reg == adcsq_pkg::ADCSQ_STAT_OFFS && w_data_reg[0])
                irq_flag_reg <= 1'b0;
            // wake only on a sleeping completion with irq enabled [RULE3]
            wake_o <= done && sleep_i && cfg_reg[adcsq_pkg::ADCSQ_CFG_IRQEN_BIT];
            // power down in sleep, enable bit untouched [RULE4] [RULE5]
            if (!sleep_i)
                asleep_off_reg <= 1'b0;
            else if (sleep_abort || (!rc_clk_sel && !busy)
                     || (done && !cfg_reg[adcsq_pkg::ADCSQ_CFG_IRQEN_BIT]))
                asleep_off_reg <= 1'b1;
            converter_powered_o <= converter_channel_control_reg[adcsq_pkg::ADCSQ_EN_BIT]
                                   && !asleep_off_reg; // [RULE12]
            conversion_done_irq_flag_o <= done || irq_flag_reg;
            trigger_timer_count_clr_o <= compare_trigger_unit_i; // [RULE6]
        end
    end

    // ==========================================================
    // input mux decode, one-hot per channel
    genvar g;
    generate
        for (g = 0; g < 12; g++)
        begin : g_ain
            always_ff @(posedge clk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    analog_input_sel_o[g] <= 1'b0;
                else
                    analog_input_sel_o[g] <= chs == 5'(g); // [RULE8] [RULE9]
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            temp_indicator_sel_o         <= 1'b0;
            dac_output_sel_o             <= 1'b0;
            fixed_reference_buffer_sel_o <= 1'b0;
        end
        else
        begin
            temp_indicator_sel_o         <= chs == adcsq_pkg::ADCSQ_CH_TEMP; // [RULE10]
            dac_output_sel_o             <= chs == adcsq_pkg::ADCSQ_CH_DAC;
            fixed_reference_buffer_sel_o <= chs == adcsq_pkg::ADCSQ_CH_FVR;
        end
    end

    // ==========================================================
    // axi4-lite read, one cycle after address accepted
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= adcsq_pkg::ADCSQ_AXI_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= adcsq_pkg::ADCSQ_AXI_OKAY;
                unique case (s_axi_araddr)
                    adcsq_pkg::ADCSQ_CTRL_OFFS:
                        s_axi_rdata <= {24'h000000, converter_channel_control_reg};
                    adcsq_pkg::ADCSQ_CFG_OFFS:
                        s_axi_rdata <= {24'h000000, cfg_reg};
                    adcsq_pkg::ADCSQ_RESULT_OFFS:
                        s_axi_rdata <= {22'h000000, result_reg};
                    adcsq_pkg::ADCSQ_STAT_OFFS:
                        s_axi_rdata <= {28'h0000000, asleep_off_reg, busy,
                                        delay_pend_reg, irq_flag_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= adcsq_pkg::ADCSQ_AXI_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- tb/adcsq_top_assertions.sv ----
// checker: port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adcsq_checker (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        compare_trigger_unit_i,
    input wire logic        trigger_timer_count_clr_o,
    input wire logic        wake_o,
    input wire logic        sleep_i,
    input wire logic [11:0] analog_input_sel_o,
    input wire logic        temp_indicator_sel_o,
    input wire logic        dac_output_sel_o,
    input wire logic        fixed_reference_buffer_sel_o,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    // ==========================================================
    // single clock domain, reset kills every check
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    trig_clr_a: assert property (compare_trigger_unit_i |=> trigger_timer_count_clr_o)
        else $error("timer clear missing after trigger");
    clr_cause_a: assert property (trigger_timer_count_clr_o
        |-> $past(compare_trigger_unit_i)) else $error("timer clear without trigger");
    sel_onehot_a: assert property ($onehot0({analog_input_sel_o, temp_indicator_sel_o,
        dac_output_sel_o, fixed_reference_buffer_sel_o})) else $error("two channels selected");
    wake_pulse_a: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
        else $error("wake while awake");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0)
        else $error("upper read bits set");
endmodule
bind adcsq_top adcsq_checker i_chk (.*);

// ---- tb/adcsq_top_tb_top.sv ----
// testbench: random and directed checks of the converter sequencer
`timescale 1ns/1ps
module adcsq_top_tb_top;
    localparam int HD = 8;
    localparam int IC = 4;
    logic        clk_i = 1'h0, sys_rst_i = 1'h1, sleep_i = 1'h0, comparator_i = 1'h0;
    logic        compare_trigger_unit_i = 1'h0, s_axi_bready = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] analog_input_sel_o;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_o;
    logic        trigger_timer_count_clr_o, converter_powered_o, conversion_done_irq_flag_o;
    logic        temp_indicator_sel_o, dac_output_sel_o, fixed_reference_buffer_sel_o;
    int          n_mismatch = 0, cmp_count = 0, seed = 32'h9711, t;
    adcsq_top #(.RC_HALF_DIV(HD), .INSN_CYCLES(IC)) i_dut (.*);
    // ==========================================================
    // clock and helpers
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic close_out;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w)
        begin
            @(posedge clk_i);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid) @(posedge clk_i);
        chk(s_axi_bresp, {a[1:0] != 2'h0, 1'h0});
        s_axi_bready <= 1'h0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        while (!s_axi_rvalid) @(posedge clk_i);
        rd = s_axi_rdata;
        chk(s_axi_rresp, {a[1:0] != 2'h0, 1'h0});
        s_axi_rready <= 1'h0;
    endtask
    // clock, enable, settle, then go; comparator held
    task automatic start(input logic [7:0] cfg, input logic c);
        comparator_i <= c;
        wr(4'h4, {24'h0, cfg});
        wr(4'h0, 32'h1);
        wt(8);
        wr(4'h0, 32'h3);
        t = 0;
    endtask
    task automatic wait_flag;
        while (!conversion_done_irq_flag_o && t < 1000)
        begin
            @(posedge clk_i);
            t++;
        end
    endtask
    function automatic logic [14:0] exp_sel(input logic [4:0] c);
        exp_sel = 15'h0;
        if (c <= 5'h0B) exp_sel[c] = 1'h1;
        if (c >= 5'h1D) exp_sel[c - 5'h11] = 1'h1;
    endfunction
    // ==========================================================
    // watchdog sized well above the expected run
    initial
    begin
        wt(30000);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        wt(16);
        sys_rst_i <= 1'h0;
        rdr(4'h0); chk(rd, 32'h0);
        wr(4'h0, 32'hFC); rdr(4'h0); chk(rd, 32'h7C);
        wr(4'h2, 32'h1); rdr(4'h2); chk(rd, 32'h0);
        for (int c = 0; c < 32; c++)
        begin
            wr(4'h0, 32'(c) << 2);
            wt(2);
            chk({fixed_reference_buffer_sel_o, dac_output_sel_o, temp_indicator_sel_o,
                analog_input_sel_o}, exp_sel(5'(c)));
        end
        // full run on the divided system clock, polled to completion
        start(8'hF0, 1'($random(seed))); rdr(4'h0); chk(rd[1], 1'h1);
        while (rd[1]) rdr(4'h0);
        chk(conversion_done_irq_flag_o, 1'h1);
        rdr(4'h8); chk(rd, {22'h0, {10{comparator_i}}});
        wr(4'hC, 32'h1); wt(2); chk(conversion_done_irq_flag_o, 1'h0);
        // abort midway with the opposite level so the result must change
        start(8'hF0, !comparator_i); wt(100); wr(4'h0, 32'h1);
        rdr(4'h0); chk(rd[1], 1'h0);
        rdr(4'h8); chk(rd, {22'h0, {10{comparator_i}}});
        wr(4'hC, 32'h1);
        // rc clock awake: length of a whole conversion
        start(8'h01, 1'($random(seed))); wait_flag();
        chk(t >= 23 * HD && t <= 23 * HD + IC + HD + 6, 1'h1);
        wr(4'hC, 32'h1);
        // rc clock, irq on, sleeping: wakes at completion
        start(8'h03, 1'($random(seed))); sleep_i <= 1'h1;
        while (!wake_o && t < 1000) begin @(posedge clk_i); t++; end
        chk(wake_o, 1'h1); wt(2); chk(conversion_done_irq_flag_o, 1'h1);
        sleep_i <= 1'h0; wr(4'hC, 32'h1);
        // rc clock, irq off, sleeping: powers down, enable kept
        start(8'h01, 1'($random(seed))); sleep_i <= 1'h1; wait_flag(); wt(2);
        chk(converter_powered_o, 1'h0); rdr(4'h0); chk(rd[0], 1'h1);
        rdr(4'h8); chk(rd, {22'h0, {10{comparator_i}}});
        sleep_i <= 1'h0; wr(4'hC, 32'h1);
        // system clock source, sleeping: aborted and powered down
        start(8'hF0, 1'($random(seed))); wt(50); sleep_i <= 1'h1; wt(500);
        chk({conversion_done_irq_flag_o, converter_powered_o}, 2'h0);
        rdr(4'h0); chk(rd[0], 1'h1);
        sleep_i <= 1'h0; wt(4);
        // hardware trigger sets go; timing left to software
        compare_trigger_unit_i <= 1'h1; @(posedge clk_i); compare_trigger_unit_i <= 1'h0;
        rdr(4'h0); chk(rd[1], 1'h1);
        while (rd[1]) rdr(4'h0);
        // disabled converter ignores go and is unpowered
        wr(4'h0, 32'h0); wt(2); chk(converter_powered_o, 1'h0);
        wr(4'h0, 32'h2); rdr(4'h0); chk(rd[1], 1'h0);
        close_out();
    end
endmodule
